// file: tlic_core_model.sv
// Behavioural core: instruction boundary and return strobe
`default_nettype none
module tlic_core_model (
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic stall_in,
  input  wire logic ret_req_in,
  input  wire logic push_pc_in,
  input  wire logic load_pc_in,
  output var  logic core_ready_out,
  output var  logic reti_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // No boundary while stalled or while the vector is being taken
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_ready_out <= 1'b0;
      reti_out       <= 1'b0;
    end else begin
      core_ready_out <= !stall_in && !push_pc_in && !load_pc_in;
      reti_out       <= ret_req_in;
    end
  end
endmodule
`default_nettype wire

// file: tlic_ctrl.v
// Two-level interrupt controller with special-function registers
`include "tlic_regs.vh"
`default_nettype none

module tlic_ctrl #(
  parameter       N              = `TLIC_NSRC,
  parameter       W              = 4,
  parameter [0:0] WDOG_PRIO_HIGH = 1'b1
) (
  input  wire          clock_in,
  input  wire          resetn_in,
  // Byte access port
  input  wire [7:0]    sfr_addr_in,
  input  wire          sfr_wr_in,
  input  wire [7:0]    sfr_wdata_in,
  input  wire          sfr_rd_in,
  output wire [7:0]    sfr_rdata_out,
  output wire          sfr_hit_out,
  // Bit access port
  input  wire          bit_wr_in,
  input  wire [7:0]    bit_addr_in,
  input  wire          bit_wdata_in,
  // Request sources
  input  wire          supply_monitor_request_in,
  input  wire          watchdog_request_in,
  input  wire          ext0_request_in,
  input  wire [1:0]    adc_ready_flags_in,
  input  wire          timer0_overflow_in,
  input  wire          ext1_request_in,
  input  wire          timer1_overflow_in,
  input  wire [1:0]    serial_if_flags_in,
  input  wire [1:0]    uart_rx_tx_flags_in,
  input  wire [1:0]    timer2_flags_in,
  input  wire          tic_request_in,
  // Core handshake
  input  wire          core_ready_in,
  input  wire          reti_in,
  output wire          irq_pending_out,
  output wire          push_pc_out,
  output wire          load_pc_out,
  output wire [15:0]   vector_out,
  output wire [N-1:0]  source_ack_out,
  output wire [1:0]    in_service_out
);

  reg  [7:0]   ie_r;
  reg  [7:0]   ip_r;
  reg  [7:0]   ie2_r;
  reg  [7:0]   rdata_r;
  reg          hit_r;
  reg  [1:0]   state_r;
  reg  [1:0]   state_nxt;
  reg  [W-1:0] sel_r;
  reg          sel_high_r;
  reg  [15:0]  vector_r;
  reg  [15:0]  vector_nxt;
  reg  [N-1:0] ack_r;
  reg          ins_high_r;
  reg          ins_low_r;
  reg  [7:0]   ie_nxt;
  reg  [7:0]   ip_nxt;
  reg  [7:0]   ie2_nxt;
  reg  [7:0]   rd_val;
  reg          rd_hit;

  wire [N-1:0] raw_req;
  wire [N-1:0] src_en;
  wire [N-1:0] src_high;
  wire [N-1:0] eligible;
  wire [N-1:0] high_req;
  wire [N-1:0] low_req;
  wire         high_found;
  wire         low_found;
  wire [W-1:0] high_index;
  wire [W-1:0] low_index;
  wire         any_win;
  wire [W-1:0] win_index;
  wire         ie_bit_hit;
  wire         ip_bit_hit;

  // Sequencer state codes and bit-addressable register bases
  localparam [1:0] ST_IDLE = `TLIC_ST_IDLE;
  localparam [1:0] ST_PUSH = `TLIC_ST_PUSH;
  localparam [1:0] ST_LOAD = `TLIC_ST_LOAD;
  localparam [7:0] IE_BASE = `TLIC_ADDR_IE;
  localparam [7:0] IP_BASE = `TLIC_ADDR_IP;

  // Request levels gathered in polling order
  assign raw_req[`TLIC_SRC_PSM]  = supply_monitor_request_in;
  assign raw_req[`TLIC_SRC_WDS]  = watchdog_request_in;
  assign raw_req[`TLIC_SRC_EXT0] = ext0_request_in;
  assign raw_req[`TLIC_SRC_ADC]  = |adc_ready_flags_in;
  assign raw_req[`TLIC_SRC_T0]   = timer0_overflow_in;
  assign raw_req[`TLIC_SRC_EXT1] = ext1_request_in;
  assign raw_req[`TLIC_SRC_T1]   = timer1_overflow_in;
  assign raw_req[`TLIC_SRC_SER]  = |serial_if_flags_in;
  assign raw_req[`TLIC_SRC_UART] = |uart_rx_tx_flags_in;
  assign raw_req[`TLIC_SRC_T2]   = |timer2_flags_in;
  assign raw_req[`TLIC_SRC_TIC]  = tic_request_in;

  // Per-source enables; watchdog has no enable bit of its own
  assign src_en[`TLIC_SRC_PSM]  = ie2_r[`TLIC_IE2_EPSM];
  assign src_en[`TLIC_SRC_WDS]  = 1'b1;
  assign src_en[`TLIC_SRC_EXT0] = ie_r[`TLIC_IE_EXT0];
  assign src_en[`TLIC_SRC_ADC]  = ie_r[`TLIC_IE_ADC];
  assign src_en[`TLIC_SRC_T0]   = ie_r[`TLIC_IE_T0];
  assign src_en[`TLIC_SRC_EXT1] = ie_r[`TLIC_IE_EXT1];
  assign src_en[`TLIC_SRC_T1]   = ie_r[`TLIC_IE_T1];
  assign src_en[`TLIC_SRC_SER]  = ie2_r[`TLIC_IE2_ESER];
  assign src_en[`TLIC_SRC_UART] = ie_r[`TLIC_IE_UART];
  assign src_en[`TLIC_SRC_T2]   = ie_r[`TLIC_IE_T2];
  assign src_en[`TLIC_SRC_TIC]  = ie2_r[`TLIC_IE2_ETIC];

  // Per-source priority level, 1 = high
  assign src_high[`TLIC_SRC_PSM]  = ie2_r[`TLIC_IE2_SUPPLY_MONITOR_PRIORITY];
  assign src_high[`TLIC_SRC_WDS]  = WDOG_PRIO_HIGH;
  assign src_high[`TLIC_SRC_EXT0] = ip_r[`TLIC_IP_EXT0];
  assign src_high[`TLIC_SRC_ADC]  = ip_r[`TLIC_IP_ADC];
  assign src_high[`TLIC_SRC_T0]   = ip_r[`TLIC_IP_T0];
  assign src_high[`TLIC_SRC_EXT1] = ip_r[`TLIC_IP_EXT1];
  assign src_high[`TLIC_SRC_T1]   = ip_r[`TLIC_IP_T1];
  assign src_high[`TLIC_SRC_SER]  = ie2_r[`TLIC_IE2_PSER];
  assign src_high[`TLIC_SRC_UART] = ip_r[`TLIC_IP_UART];
  assign src_high[`TLIC_SRC_T2]   = ip_r[`TLIC_IP_T2];
  assign src_high[`TLIC_SRC_TIC]  = ie2_r[`TLIC_IE2_PTIC];

  // Gate by own and global enable
  assign eligible = raw_req & src_en & {N{ie_r[`TLIC_IE_GLOBAL]}};

  // Level blocking: high blocked by high in service, low by either
  assign high_req = eligible & src_high & {N{~ins_high_r}};
  assign low_req  = eligible & ~src_high & {N{~ins_high_r & ~ins_low_r}};

  tlic_pick #(
    .N (N),
    .W (W)
  ) u_pick_high (
    .req_in    (high_req),
    .found_out (high_found),
    .index_out (high_index)
  );

  tlic_pick #(
    .N (N),
    .W (W)
  ) u_pick_low (
    .req_in    (low_req),
    .found_out (low_found),
    .index_out (low_index)
  );

  // High level wins over low when both request
  assign any_win   = high_found | low_found;
  assign win_index = high_found ? high_index : low_index;

  // Vector lookup for the chosen source
  always @* begin
    case (win_index)
      `TLIC_SRC_EXT0: vector_nxt = `TLIC_VEC_EXT0;
      `TLIC_SRC_T0:   vector_nxt = `TLIC_VEC_T0;
      `TLIC_SRC_EXT1: vector_nxt = `TLIC_VEC_EXT1;
      `TLIC_SRC_T1:   vector_nxt = `TLIC_VEC_T1;
      `TLIC_SRC_UART: vector_nxt = `TLIC_VEC_UART;
      `TLIC_SRC_T2:   vector_nxt = `TLIC_VEC_T2;
      `TLIC_SRC_ADC:  vector_nxt = `TLIC_VEC_ADC;
      `TLIC_SRC_SER:  vector_nxt = `TLIC_VEC_SER;
      `TLIC_SRC_PSM:  vector_nxt = `TLIC_VEC_PSM;
      `TLIC_SRC_TIC:  vector_nxt = `TLIC_VEC_TIC;
      `TLIC_SRC_WDS:  vector_nxt = `TLIC_VEC_WDS;
      default:        vector_nxt = `TLIC_VEC_EXT0;
    endcase
  end

  // Bit access decode: enable and priority registers only
  assign ie_bit_hit = bit_wr_in &&
    (bit_addr_in[`TLIC_BITREG_MSB:`TLIC_BITREG_LSB] ==
     IE_BASE[`TLIC_BITREG_MSB:`TLIC_BITREG_LSB]);
  assign ip_bit_hit = bit_wr_in &&
    (bit_addr_in[`TLIC_BITREG_MSB:`TLIC_BITREG_LSB] ==
     IP_BASE[`TLIC_BITREG_MSB:`TLIC_BITREG_LSB]);

  // Next register values from byte and bit writes
  always @* begin
    ie_nxt  = ie_r;
    ip_nxt  = ip_r;
    ie2_nxt = ie2_r;
    if (sfr_wr_in && sfr_addr_in == `TLIC_ADDR_IE) begin
      ie_nxt = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == `TLIC_ADDR_IP) begin
      ip_nxt = sfr_wdata_in & `TLIC_IP_WMASK;
    end
    if (sfr_wr_in && sfr_addr_in == `TLIC_ADDR_IE2) begin
      ie2_nxt = sfr_wdata_in & `TLIC_IE2_WMASK;
    end
    if (ie_bit_hit) begin
      ie_nxt[bit_addr_in[2:0]] = bit_wdata_in;
    end
    if (ip_bit_hit) begin
      ip_nxt[bit_addr_in[2:0]] = bit_wdata_in;
      ip_nxt = ip_nxt & `TLIC_IP_WMASK;
    end
  end

  // Configuration registers
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ie_r  <= `TLIC_RST_IE;
      ip_r  <= `TLIC_RST_IP;
      ie2_r <= `TLIC_RST_IE2 & `TLIC_IE2_WMASK;
    end else begin
      ie_r  <= ie_nxt;
      ip_r  <= ip_nxt;
      ie2_r <= ie2_nxt;
    end
  end

  // Read mux; unimplemented secondary bit 7 reads as its reset value
  always @* begin
    rd_val = `TLIC_ZERO8;
    rd_hit = 1'b0;
    case (sfr_addr_in)
      `TLIC_ADDR_IE: begin
        rd_val = ie_r;
        rd_hit = 1'b1;
      end
      `TLIC_ADDR_IP: begin
        rd_val = ip_r;
        rd_hit = 1'b1;
      end
      `TLIC_ADDR_IE2: begin
        rd_val = ie2_r | `TLIC_IE2_RDFIX;
        rd_hit = 1'b1;
      end
      default: begin
        rd_val = `TLIC_ZERO8;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= `TLIC_ZERO8;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= sfr_rd_in ? rd_val : `TLIC_ZERO8;
      hit_r   <= sfr_rd_in & rd_hit;
    end
  end

  // Acceptance sequencer: push program counter, then load vector
  always @* begin
    case (state_r)
      ST_IDLE: begin
        if (any_win && core_ready_in) begin
          state_nxt = ST_PUSH;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PUSH: state_nxt = ST_LOAD;
      ST_LOAD: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer, winner latch, acknowledge and vector
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= ST_IDLE;
      sel_r      <= {W{1'b0}};
      sel_high_r <= 1'b0;
      vector_r   <= `TLIC_VEC_EXT0;
      ack_r      <= {N{1'b0}};
    end else begin
      state_r <= state_nxt;
      ack_r   <= {N{1'b0}};
      if (state_r == ST_IDLE && any_win && core_ready_in) begin
        sel_r      <= win_index;
        sel_high_r <= high_found;
        vector_r   <= vector_nxt;
      end
      if (state_r == ST_PUSH) begin
        ack_r <= {{(N-1){1'b0}}, 1'b1} << sel_r;
      end
    end
  end

  // In-service levels: return clears the highest active one
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ins_high_r <= 1'b0;
      ins_low_r  <= 1'b0;
    end else begin
      if (reti_in) begin
        if (ins_high_r) begin
          ins_high_r <= 1'b0;
        end else begin
          ins_low_r <= 1'b0;
        end
      end
      if (state_r == ST_LOAD) begin
        if (sel_high_r) begin
          ins_high_r <= 1'b1;
        end else begin
          ins_low_r <= 1'b1;
        end
      end
    end
  end

  // Outputs
  assign irq_pending_out = any_win && (state_r == ST_IDLE);
  assign push_pc_out     = (state_r == ST_PUSH);
  assign load_pc_out     = (state_r == ST_LOAD);
  assign vector_out      = vector_r;
  assign source_ack_out  = ack_r;
  assign in_service_out  = {ins_high_r, ins_low_r};
  assign sfr_rdata_out   = rdata_r;
  assign sfr_hit_out     = hit_r;

endmodule

`default_nettype wire

// file: tlic_ctrl_chk_sva.sv
// Port assertions of the interrupt controller
`default_nettype none
module tlic_ctrl_chk #(parameter N = 11) (
  input wire logic         clock_in,
  input wire logic         resetn_in,
  input wire logic [7:0]   sfr_addr_in,
  input wire logic         sfr_rd_in,
  input wire logic [7:0]   sfr_rdata_out,
  input wire logic         sfr_hit_out,
  input wire logic         core_ready_in,
  input wire logic         reti_in,
  input wire logic         irq_pending_out,
  input wire logic         push_pc_out,
  input wire logic         load_pc_out,
  input wire logic [15:0]  vector_out,
  input wire logic [N-1:0] source_ack_out,
  input wire logic [1:0]   in_service_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Acceptance: push, load, then level in service
  sequence s_take; irq_pending_out && core_ready_in; endsequence
  sequence s_steps; push_pc_out ##1 load_pc_out ##1 (in_service_out != 2'b00); endsequence
  property p_accept; s_take |=> s_steps; endproperty
  a_accept: assert property (p_accept) else $error("acceptance steps wrong");
  property p_ack; load_pc_out == $onehot(source_ack_out); endproperty
  a_ack: assert property (p_ack) else $error("source ack wrong");
  property p_vec; $changed(vector_out) |-> push_pc_out; endproperty
  a_vec: assert property (p_vec) else $error("vector moved outside push");
  property p_busy; push_pc_out || load_pc_out |-> !irq_pending_out; endproperty
  a_busy: assert property (p_busy) else $error("pending while busy");
  property p_hblk; in_service_out[1] |-> !irq_pending_out; endproperty
  a_hblk: assert property (p_hblk) else $error("high routine not blocking");
  property p_reti; in_service_out[1] && reti_in && !load_pc_out |=> !in_service_out[1]; endproperty
  a_reti: assert property (p_reti) else $error("return left high level set");
  property p_hit;
    sfr_rd_in |=> sfr_hit_out == ($past(sfr_addr_in) inside {8'hA8, 8'hA9, 8'hB8});
  endproperty
  a_hit: assert property (p_hit) else $error("read hit wrong");
  property p_sec; sfr_rd_in && sfr_addr_in == 8'hA9 |=> sfr_rdata_out[7] && !sfr_rdata_out[3];
  endproperty
  a_sec: assert property (p_sec) else $error("secondary fixed bits wrong");
  property p_pri; sfr_rd_in && sfr_addr_in == 8'hB8 |=> !sfr_rdata_out[7]; endproperty
  a_pri: assert property (p_pri) else $error("priority bit 7 set");
endmodule
bind tlic_ctrl tlic_ctrl_chk #(.N(N)) u_chk (.clock_in(clock_in), .resetn_in(resetn_in),
  .sfr_addr_in(sfr_addr_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
  .sfr_hit_out(sfr_hit_out), .core_ready_in(core_ready_in), .reti_in(reti_in),
  .irq_pending_out(irq_pending_out), .push_pc_out(push_pc_out), .load_pc_out(load_pc_out),
  .vector_out(vector_out), .source_ack_out(source_ack_out), .in_service_out(in_service_out));
`default_nettype wire

// file: tlic_pick.v
// Fixed-order picker: lowest set index wins
`default_nettype none

module tlic_pick #(
  parameter N = 11,
  parameter W = 4
) (
  input  wire [N-1:0] req_in,
  output reg          found_out,
  output reg  [W-1:0] index_out
);

  integer i;

  // Scan from last to first so the first set bit is kept
  always @* begin
    found_out = 1'b0;
    index_out = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req_in[i]) begin
        found_out = 1'b1;
        index_out = i[W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

// file: tlic_regs.vh
// Register map, field positions, vectors and codes of the interrupt controller
// Functional notes
// - Priority register bits 6..0: ADC, timer2, UART, timer1, ext1, timer0, ext0; 1 high.
// - Secondary register bits 6,5,4 give interval counter, supply monitor, serial priority.
// - Secondary register bits 2,1,0 enable interval counter, supply monitor, serial port.
// - Bit 7 of priority and secondary registers is unimplemented; writes ignored.
// - Secondary register at A9H, resets to A0H, byte access only.
// - An enabled high request preempts a running low service routine at once.
// - Simultaneous high and low requests: high one is vectored first.
// - An active routine blocks further requests of its own level until it ends.
// - Same-level ties follow fixed polling order, supply monitor first, interval counter last.
// - Accepting a request pushes the program counter, then loads the vector.
// - Vectors 0003H ext0, 000BH timer0, 0013H ext1, 001BH timer1, 0023H UART, 002BH timer2.
// - Vectors 0033H ADC, 003BH serial, 0043H supply monitor, 0053H counter, 005BH watchdog.
// - Enable register: bit 7 global enable, bits 6..0 per-source enables.
// - Priority register at B8H, resets to 00H, bit addressable.
`ifndef TLIC_REGS_VH
`define TLIC_REGS_VH

`define TLIC_ADDR_IE      8'hA8
`define TLIC_ADDR_IP      8'hB8
`define TLIC_ADDR_IE2     8'hA9
`define TLIC_RST_IE       8'h00
`define TLIC_RST_IP       8'h00
`define TLIC_RST_IE2      8'hA0
`define TLIC_IE2_WMASK    8'h77
`define TLIC_IP_WMASK     8'h7F
`define TLIC_IE2_RDFIX    8'h80
`define TLIC_ZERO8        8'h00
`define TLIC_BITREG_MSB   7
`define TLIC_BITREG_LSB   3

// Enable register fields
`define TLIC_IE_GLOBAL    7
`define TLIC_IE_ADC       6
`define TLIC_IE_T2        5
`define TLIC_IE_UART      4
`define TLIC_IE_T1        3
`define TLIC_IE_EXT1      2
`define TLIC_IE_T0        1
`define TLIC_IE_EXT0      0
// Priority register fields
`define TLIC_IP_ADC       6
`define TLIC_IP_T2        5
`define TLIC_IP_UART      4
`define TLIC_IP_T1        3
`define TLIC_IP_EXT1      2
`define TLIC_IP_T0        1
`define TLIC_IP_EXT0      0
// Secondary register fields
`define TLIC_IE2_PTIC     6
`define TLIC_IE2_SUPPLY_MONITOR_PRIORITY     5
`define TLIC_IE2_PSER     4
`define TLIC_IE2_ETIC     2
`define TLIC_IE2_EPSM     1
`define TLIC_IE2_ESER     0

// Source index, equal to polling rank (0 polled first)
`define TLIC_NSRC         11
`define TLIC_SRC_PSM      0
`define TLIC_SRC_WDS      1
`define TLIC_SRC_EXT0     2
`define TLIC_SRC_ADC      3
`define TLIC_SRC_T0       4
`define TLIC_SRC_EXT1     5
`define TLIC_SRC_T1       6
`define TLIC_SRC_SER      7
`define TLIC_SRC_UART     8
`define TLIC_SRC_T2       9
`define TLIC_SRC_TIC      10

// Vector addresses
`define TLIC_VEC_EXT0     16'h0003
`define TLIC_VEC_T0       16'h000B
`define TLIC_VEC_EXT1     16'h0013
`define TLIC_VEC_T1       16'h001B
`define TLIC_VEC_UART     16'h0023
`define TLIC_VEC_T2       16'h002B
`define TLIC_VEC_ADC      16'h0033
`define TLIC_VEC_SER      16'h003B
`define TLIC_VEC_PSM      16'h0043
`define TLIC_VEC_TIC      16'h0053
`define TLIC_VEC_WDS      16'h005B

// Acceptance sequencer states
`define TLIC_ST_IDLE      2'h0
`define TLIC_ST_PUSH      2'h1
`define TLIC_ST_LOAD      2'h2

`endif

// file: two_level_interrupt_controller_test.sv
// Self-checking bench of the two-level interrupt controller
`default_nettype none
module two_level_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in, resetn_in, sfr_wr, sfr_rd, bit_wr, bit_val, stall, ret_req, fl;
  logic        hit, ready, reti, pend, push, load;
  logic [7:0]  addr, wdata, baddr, rdata;
  logic [10:0] req, ack;
  logic [15:0] vec;
  logic [1:0]  insvc;
  int          error_cnt, samples_checked, ie, ip, ie2, w;
  // Field codes: under 8 main register bit, 8 up secondary bit, -1 none
  int          en_map[11] = '{9, -1, 0, 6, 1, 2, 3, 8, 4, 5, 10};
  int          pr_map[11] = '{13, -1, 0, 6, 1, 2, 3, 12, 4, 5, 14};
  logic [15:0] vtab[11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
                            16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};

  tlic_ctrl dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .sfr_addr_in(addr), .sfr_wr_in(sfr_wr),
    .sfr_wdata_in(wdata), .sfr_rd_in(sfr_rd), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
    .bit_wr_in(bit_wr), .bit_addr_in(baddr), .bit_wdata_in(bit_val),
    .supply_monitor_request_in(req[0]), .watchdog_request_in(req[1]),
    .ext0_request_in(req[2]), .adc_ready_flags_in({req[3] & fl, req[3] & ~fl}),
    .timer0_overflow_in(req[4]), .ext1_request_in(req[5]), .timer1_overflow_in(req[6]),
    .serial_if_flags_in({req[7] & fl, req[7] & ~fl}),
    .uart_rx_tx_flags_in({req[8] & ~fl, req[8] & fl}),
    .timer2_flags_in({req[9] & fl, req[9] & ~fl}), .tic_request_in(req[10]),
    .core_ready_in(ready), .reti_in(reti), .irq_pending_out(pend), .push_pc_out(push),
    .load_pc_out(load), .vector_out(vec), .source_ack_out(ack), .in_service_out(insvc));

  tlic_core_model core (
    .clock_in(clock_in), .resetn_in(resetn_in), .stall_in(stall), .ret_req_in(ret_req),
    .push_pc_in(push), .load_pc_in(load), .core_ready_out(ready), .reti_out(reti));

  // Clock
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Model helpers and bus tasks
  function automatic int bitof(int code, int lo);
    if (code < 0)
      return 1;
    if (code < 8)
      return (lo >> code) & 1;
    return (ie2 >> (code - 8)) & 1;
  endfunction
  function automatic int winner(output int lvl);
    lvl = 0;
    for (int l = 1; l >= 0; l--)
      for (int i = 0; i < 11; i++)
        if (req[i] && ie[7] && bitof(en_map[i], ie) == 1 && bitof(pr_map[i], ip) == l) begin
          lvl = l;
          return i;
        end
    return -1;
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock_in);
    sfr_wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clock_in);
    sfr_wr = 1'b0;
    if (a == 8'hA8) ie = d;
    if (a == 8'hB8) ip = d & 8'h7F;
    if (a == 8'hA9) ie2 = d & 8'h77;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic h);
    @(negedge clock_in);
    sfr_rd = 1'b1;
    addr = a;
    @(negedge clock_in);
    sfr_rd = 1'b0;
    chk("read data", 16'(rdata), 16'(e));
    chk("read hit", 16'(hit), 16'(h));
  endtask
  task automatic bw(logic [7:0] a, logic v);
    @(negedge clock_in);
    bit_wr = 1'b1;
    baddr = a;
    bit_val = v;
    @(negedge clock_in);
    bit_wr = 1'b0;
    if (a < 8'hB8)
      ie[a - 8'hA8] = v;
    else
      ip[a - 8'hB8] = v;
    ip = ip & 8'h7F;
  endtask
  task automatic accept(int idx, logic [1:0] m);
    int n;
    n = 0;
    while (push !== 1'b1 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      conclude();
    end
    chk("vector", vec, vtab[idx]);
    @(negedge clock_in);
    chk("load", 16'(load), 16'h0001);
    chk("ack", 16'(ack), 16'(1 << idx));
    req = 11'h000;
    @(negedge clock_in);
    chk("in service", 16'(insvc), 16'(m));
  endtask
  task automatic ret(logic [1:0] m);
    @(negedge clock_in);
    ret_req = 1'b1;
    @(negedge clock_in);
    ret_req = 1'b0;
    repeat (2) @(negedge clock_in);
    chk("in service", 16'(insvc), 16'(m));
  endtask
  task automatic run_case();
    int k, l;
    k = winner(l);
    if (k >= 0) begin
      accept(k, l ? 2'b10 : 2'b01);
      ret(2'b00);
    end
    req = 11'h000; // No request left over for the next configuration
  endtask

  // Main sequence
  initial begin
    {resetn_in, sfr_wr, sfr_rd, bit_wr, bit_val, stall, ret_req, fl} = 8'h00;
    {addr, wdata, baddr, req} = 35'h0;
    error_cnt = 0;
    samples_checked = 0;
    ie = 0;
    ip = 0;
    ie2 = 8'h20;
    void'($urandom(72525));
    repeat (5) @(negedge clock_in);
    resetn_in = 1'b1;
    rd(8'hA8, 8'h00, 1'b1);
    rd(8'hB8, 8'h00, 1'b1);
    rd(8'hA9, 8'hA0, 1'b1);
    rd(8'hAA, 8'h00, 1'b0);
    wr(8'hA9, 8'hF7);
    rd(8'hA9, 8'hF7, 1'b1);
    wr(8'hB8, 8'hFF);
    bw(8'hBB, 1'b0);
    bw(8'hBF, 1'b1);
    rd(8'hB8, 8'h77, 1'b1);
    wr(8'hA8, 8'h7F);
    bw(8'hAF, 1'b1);
    rd(8'hA8, 8'hFF, 1'b1);
    wr(8'hB8, 8'h00);
    wr(8'hA9, 8'h07);
    for (int i = 0; i < 11; i++) begin
      fl = i[0];
      req = 11'h001 << i;
      run_case();
    end
    for (int k = 0; k < 60; k++) begin
      wr(8'hA8, 8'($urandom));
      wr(8'hB8, 8'($urandom));
      wr(8'hA9, 8'($urandom) & 8'h77);
      stall = 1'b1;
      @(negedge clock_in);
      req = 11'($urandom);
      fl = 1'($urandom);
      // Core held off, so pending is settled and no acceptance starts
      @(negedge clock_in);
      chk("pending", 16'(pend), 16'(winner(w) >= 0));
      stall = 1'b0;
      run_case();
    end
    req = 11'h000;
    wr(8'hA8, 8'hFF);
    wr(8'hB8, 8'h02);
    wr(8'hA9, 8'h00);
    req = 11'h004;
    accept(2, 2'b01);
    req = 11'h020;
    repeat (4) @(negedge clock_in);
    chk("pending", 16'(pend), 16'h0000);
    req = 11'h030;
    accept(4, 2'b11);
    ret(2'b01);
    req = 11'h020;
    @(negedge clock_in);
    chk("pending", 16'(pend), 16'h0000);
    ret(2'b00);
    accept(5, 2'b01);
    ret(2'b00);
    conclude();
  end
endmodule
`default_nettype wire
